// ---- include/cir_pkg.sv ----
// Summary of operation
// - After power-up the unit holds itself in reset for a short time and leaves it unaided.
// - Writing 0 to control bit 1 puts the subsystem logic back into reset at any time.
// - Control bit 0 low holds the outgoing data-frame interface in reset; high releases it.
// - Control bit 2 low clears the status and error bits of the interface status register.
// - Reading the control register returns the three control bits in bits 2..0, zeros above.
// - Status bits 5..4 give the last outcome: 00 accepted, 01 unknown, 10 forbidden, 11 timeout.
// - Status bits 3..0 flag response timeout, forbidden read, forbidden broadcast, overlap.
// - Undefined addresses, writes to read-only and reads of write-only answer unknown (01).
// - Every non-broadcast subsystem command is passed on; forbidden or timeout only mark a hardware fault.
// - The delay register holds the last subsystem delay in link periods, reset value 0x01ff.
// - Control and time-stamp reset accept broadcast; a time-stamp reset write pulses the reset.
// - Every register returns to its default at power-up and after a subsystem reset.
// - Out of reset, host accesses are served except forbidden broadcasts; a start bit during an open command is ignored and flagged.
// - Register words are 16 bits, bit 15 the most significant and bit 0 the least.
package cir_pkg;
  typedef logic [7:0] cir_addr_t;
  typedef logic [15:0] cir_word_t;
  // Register offsets; addresses from the subsystem base upward go to the subsystem.
  localparam cir_addr_t ADR_STATUS = 8'h00;
  localparam cir_addr_t ADR_CONTROL = 8'h01;
  localparam cir_addr_t ADR_DELAY = 8'h02;
  localparam cir_addr_t ADR_TSRST = 8'h03;
  localparam cir_addr_t ADR_SUB_BASE = 8'h20;
  // Field positions.
  localparam int CTL_DATA_RSTN = 0;
  localparam int CTL_SUB_RSTN = 1;
  localparam int CTL_CLR_N = 2;
  localparam int ST_OVERLAP = 0;
  localparam int ST_FORB_BC = 1;
  localparam int ST_FORB_RD = 2;
  localparam int ST_TIMEOUT = 3;
  localparam int ST_RESP_LO = 4;
  localparam int CTL_W = 3;
  localparam int STAT_W = 6;
  localparam int DLY_W = 9;
  // Reset values.
  localparam logic [2:0] CTL_RESET = 3'h3;
  localparam logic [5:0] STAT_RESET = 6'h00;
  localparam logic [8:0] DLY_RESET = 9'h1ff;
  // Link frame: write flag, broadcast flag, address, data; answer: start, status, data.
  localparam int FRM_BITS = 26;
  localparam int RET_BITS = 19;
  // Timing.
  localparam int CLK_MHZ = 250;
  localparam int RST_TIME_NS = 1000;
  localparam int RST_CYCLES = (RST_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SUB_TIMEOUT = 511;
  typedef enum logic [1:0] {
    CIR_RS_OK = 2'b00,
    CIR_RS_UNKNOWN = 2'b01,
    CIR_RS_FORBID = 2'b10,
    CIR_RS_TIMEOUT = 2'b11
  } cir_resp_e;
  typedef struct packed {
    logic we;
    cir_addr_t addr;
    cir_word_t wdata;
  } cir_sub_cmd_s;
endpackage

// ---- rtl/cir_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module cir_sync
  import cir_pkg::*;
#(
  parameter int W = 2
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cir_sync_s;
  cir_sync_s st;
  cir_sync_s next_st;

  if (W < 1)
  begin : g_chk
    $error("cir_sync needs W of at least 1");
  end

  // The first stage feeds only the second, so metastability settles there.
  always_comb
  begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign q_o = st.s2;
endmodule
`default_nettype wire

// ---- rtl/cir_rst_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
module cir_rst_gen
  import cir_pkg::*;
#(
  parameter int CYCLES = RST_CYCLES
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Request to re-enter reset, and the stretched reset level.
  input wire logic trig_i,
  output logic busy_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic busy;
  } cir_rst_s;
  cir_rst_s st;
  cir_rst_s next_st;

  if (CYCLES < 1 || CYCLES > 65535)
  begin : g_chk
    $error("cir_rst_gen CYCLES out of range");
  end

  // Count down the reset window, then release without outside help.
  always_comb
  begin
    next_st = st;
    if (trig_i)
    begin
      next_st.cnt = 16'(CYCLES);
      next_st.busy = 1'b1;
    end
    else if (st.cnt != 16'h0000)
    begin
      next_st.cnt = st.cnt - 16'h0001;
    end
    else
    begin
      next_st.busy = 1'b0;
    end
  end

  // Power-up loads the full window so the unit starts in reset.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st.cnt <= 16'(CYCLES);
      st.busy <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign busy_o = st.busy;
endmodule
`default_nettype wire

// ---- rtl/cir_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module cir_regs
  import cir_pkg::*;
#(
  parameter int RESET_CYCLES = RST_CYCLES,
  parameter int TIMEOUT_PERIODS = SUB_TIMEOUT
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Host command link.
  input wire logic link_clk_i,
  input wire logic link_cmd_i,
  output logic link_ret_o,
  // Subsystem access port.
  output logic sub_req_o,
  output cir_sub_cmd_s sub_cmd_o,
  input wire logic sub_ack_i,
  input wire logic sub_err_i,
  input wire logic [15:0] sub_rdata_i,
  // Reset and strobe outputs.
  output logic sub_reset_o,
  output logic data_if_reset_o,
  output logic timestamp_reset_o
);
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_RX = 3'b001,
    PH_DEC = 3'b010,
    PH_WAIT = 3'b011,
    PH_TX = 3'b100
  } cir_phase_e;

  typedef struct packed {
    cir_phase_e ph;
    logic lk_q;
    logic [4:0] cnt;
    logic [FRM_BITS-1:0] rx;
    logic [RET_BITS-1:0] tx;
    logic [CTL_W-1:0] ctrl;
    logic [STAT_W-1:0] stat;
    logic [DLY_W-1:0] dly;
    logic [DLY_W-1:0] dcnt;
    logic ret;
    logic req;
    cir_sub_cmd_s cmd;
    logic ts;
    logic dif_rst;
    logic rst_req;
  } cir_state_s;

  localparam cir_state_s ST_RST = '{
    ph: PH_IDLE, lk_q: 1'b0, cnt: 5'h00, rx: '0, tx: '0,
    ctrl: CTL_RESET, stat: STAT_RESET, dly: DLY_RESET, dcnt: '0,
    ret: 1'b0, req: 1'b0, cmd: '0, ts: 1'b0, dif_rst: 1'b0,
    rst_req: 1'b0};

  if (TIMEOUT_PERIODS < 1 || TIMEOUT_PERIODS > 511)
  begin : g_chk
    $error("cir_regs TIMEOUT_PERIODS must be 1 to 511");
  end

  cir_state_s st;
  cir_state_s next_st;
  logic [1:0] sync_q;
  logic busy;
  logic lk;
  logic cmd_bit;
  logic rise;
  logic fall;

  // Link clock and command line come from the host's domain.
  cir_sync #(
    .W(2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link_clk_i, link_cmd_i}),
    .q_o(sync_q)
  );

  // Power-up and commanded resets share one stretcher.
  cir_rst_gen #(
    .CYCLES(RESET_CYCLES)
  ) u_rst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .trig_i(st.rst_req),
    .busy_o(busy)
  );

  assign lk = sync_q[1];
  assign cmd_bit = sync_q[0];
  assign rise = lk & ~st.lk_q;
  assign fall = ~lk & st.lk_q;

  // Command decode, subsystem hand-off and answer shifting in one pass.
  always_comb
  begin
    logic [STAT_W-1:0] set_v;
    logic done;
    logic reply;
    cir_resp_e rs;
    cir_word_t rd;
    logic we;
    logic bc;
    cir_addr_t ad;
    cir_word_t wd;
    set_v = '0;
    done = 1'b0;
    reply = 1'b1;
    rs = CIR_RS_OK;
    rd = '0;
    we = st.rx[25];
    bc = st.rx[24];
    ad = st.rx[23:16];
    wd = st.rx[15:0];
    next_st = st;
    next_st.lk_q = lk;
    next_st.ts = 1'b0;
    next_st.rst_req = 1'b0;
    unique case (st.ph)
      PH_IDLE:
      begin
        // A high command bit on a link rising edge starts a frame.
        if (rise && cmd_bit)
        begin
          next_st.ph = PH_RX;
          next_st.cnt = 5'h00;
        end
      end
      PH_RX:
      begin
        // Bits arrive most significant first, sampled on rising link edges.
        if (rise)
        begin
          next_st.rx = {st.rx[FRM_BITS-2:0], cmd_bit};
          next_st.cnt = st.cnt + 5'h01;
          if (st.cnt == 5'(FRM_BITS - 1))
            next_st.ph = PH_DEC;
        end
      end
      PH_DEC:
      begin
        // Broadcast reads and broadcasts to other than control or time-stamp reset are rejected as forbidden; the rest are served.
        if (bc && !we)
        begin
          set_v[ST_FORB_RD] = 1'b1;
          rs = CIR_RS_FORBID;
          reply = 1'b0;
          done = 1'b1;
        end
        else if (bc && ad != ADR_CONTROL && ad != ADR_TSRST)
        begin
          set_v[ST_FORB_BC] = 1'b1;
          rs = CIR_RS_FORBID;
          reply = 1'b0;
          done = 1'b1;
        end
        else if (ad >= ADR_SUB_BASE)
        begin
          // Every non-broadcast subsystem command is passed on, never rejected here.
          next_st.req = 1'b1;
          next_st.cmd.we = we;
          next_st.cmd.addr = ad;
          next_st.cmd.wdata = wd;
          next_st.dcnt = '0;
          next_st.ph = PH_WAIT;
        end
        else
        begin
          done = 1'b1;
          reply = !bc;
          unique case (ad)
            ADR_STATUS:
            begin
              if (we)
                rs = CIR_RS_UNKNOWN;
              else
                rd = {10'h000, st.stat};
            end
            ADR_CONTROL:
            begin
              if (we)
              begin
                next_st.ctrl = wd[CTL_W-1:0];
                next_st.rst_req = ~wd[CTL_SUB_RSTN];
              end
              else
                rd = {13'h0000, st.ctrl};
            end
            ADR_DELAY:
            begin
              if (we)
                rs = CIR_RS_UNKNOWN;
              else
                rd = {7'h00, st.dly};
            end
            ADR_TSRST:
            begin
              if (we)
                next_st.ts = 1'b1;
              else
                rs = CIR_RS_UNKNOWN;
            end
            default:
            begin
              rs = CIR_RS_UNKNOWN;
            end
          endcase
        end
      end
      PH_WAIT:
      begin
        // Delay counts host link periods from hand-off to answer.
        if (rise)
          next_st.dcnt = st.dcnt + 9'h001;
        if (sub_ack_i)
        begin
          next_st.req = 1'b0;
          next_st.dly = st.dcnt;
          rs = sub_err_i ? CIR_RS_FORBID : CIR_RS_OK;
          rd = st.cmd.we ? 16'h0000 : sub_rdata_i;
          done = 1'b1;
        end
        else if (st.dcnt == 9'(TIMEOUT_PERIODS))
        begin
          next_st.req = 1'b0;
          next_st.dly = DLY_RESET;
          set_v[ST_TIMEOUT] = 1'b1;
          rs = CIR_RS_TIMEOUT;
          done = 1'b1;
        end
      end
      PH_TX:
      begin
        // Answer bits change on falling link edges so the host samples on rising.
        if (fall)
        begin
          if (st.cnt == 5'(RET_BITS))
          begin
            next_st.ret = 1'b0;
            next_st.ph = PH_IDLE;
          end
          else
          begin
            next_st.ret = st.tx[RET_BITS-1];
            next_st.tx = {st.tx[RET_BITS-2:0], 1'b0};
            next_st.cnt = st.cnt + 5'h01;
          end
        end
      end
      default:
      begin
        next_st.ph = PH_IDLE;
      end
    endcase

    // A start bit while a command is still open is ignored and flagged.
    if ((st.ph == PH_WAIT || st.ph == PH_TX) && rise && cmd_bit)
      set_v[ST_OVERLAP] = 1'b1;

    if (done)
    begin
      set_v[ST_RESP_LO +: 2] = rs;
      next_st.ph = reply ? PH_TX : PH_IDLE;
      next_st.tx = {1'b1, rs, rd};
      next_st.cnt = 5'h00;
    end

    // Clear acts first, so an event in the same cycle survives the clear.
    if (!next_st.ctrl[CTL_CLR_N])
      next_st.stat = '0;
    if (done)
      next_st.stat[ST_RESP_LO +: 2] = rs;
    next_st.stat[ST_TIMEOUT:ST_OVERLAP] = next_st.stat[ST_TIMEOUT:ST_OVERLAP]
      | set_v[ST_TIMEOUT:ST_OVERLAP];
    next_st.dif_rst = ~next_st.ctrl[CTL_DATA_RSTN];

    // During reset every register holds its default value.
    if (busy)
    begin
      next_st = ST_RST;
      next_st.lk_q = lk;
      next_st.dif_rst = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= ST_RST;
      st.dif_rst <= 1'b1;
    end
    else
      st <= next_st;
  end

  // All outputs are flip-flop outputs.
  assign link_ret_o = st.ret;
  assign sub_req_o = st.req;
  assign sub_cmd_o = st.cmd;
  assign sub_reset_o = busy;
  assign data_if_reset_o = st.dif_rst;
  assign timestamp_reset_o = st.ts;
endmodule
`default_nettype wire

// ---- verification/cir_regs_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module cir_regs_checker
  import cir_pkg::*;
#(
  parameter int RESET_CYCLES = RST_CYCLES,
  parameter int TIMEOUT_PERIODS = SUB_TIMEOUT
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Link and subsystem side.
  input wire logic link_clk_i,
  input wire logic link_ret_o,
  input wire logic sub_req_o,
  input wire cir_sub_cmd_s sub_cmd_o,
  input wire logic sub_ack_i,
  // Reset and strobe outputs.
  input wire logic sub_reset_o,
  input wire logic timestamp_reset_o
);
  int rst_len;
  int req_len;
  // Counters bound the long waits, since a big repetition would stall the tools.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_len <= 0;
      req_len <= 0;
    end
    else
    begin
      rst_len <= sub_reset_o ? rst_len + 1 : 0;
      req_len <= sub_req_o ? req_len + 1 : 0;
    end
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RST_HOLD: assert property ($fell(rst_i) |-> sub_reset_o [*4])
    else $error("subsystem reset left too early");
  AST_RST_EXIT: assert property (rst_len <= RESET_CYCLES + 4)
    else $error("subsystem reset never left");
  AST_REQ_LEN: assert property (req_len <= TIMEOUT_PERIODS * 40)
    else $error("subsystem request outlived its timeout");
  AST_REQ_HOLD: assert property (sub_req_o && $past(sub_req_o) |-> $stable(sub_cmd_o))
    else $error("subsystem command moved during request");
  AST_REQ_DROP: assert property (sub_req_o && sub_ack_i |=> !sub_req_o)
    else $error("request held after acknowledge");
  AST_REQ_QUIET: assert property (sub_reset_o |-> !sub_req_o && !timestamp_reset_o)
    else $error("activity during subsystem reset");
  AST_TS_PULSE: assert property (timestamp_reset_o |=> !timestamp_reset_o)
    else $error("time-stamp reset longer than one cycle");
  AST_RET_FALL: assert property ($changed(link_ret_o) |-> !link_clk_i)
    else $error("answer line moved while link clock high");
endmodule
`default_nettype wire

// ---- verification/cir_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module cir_host_model
  import cir_pkg::*;
(
  // Link pins toward the device.
  output var logic lclk_o,
  output var logic cmd_o,
  input wire logic ret_i
);
  // The link clock stands still and low between frames.
  initial
  begin
    lclk_o = 1'b0;
    cmd_o = 1'b0;
  end
  // One link period; data moves after the falling edge, answers are read before the rise.
  task automatic tick(input logic b, output logic s);
    cmd_o = b;
    #62.5;
    s = ret_i;
    lclk_o = 1'b1;
    #62.5;
    lclk_o = 1'b0;
  endtask
  // Frame out MSB first, then the answer if one comes; no new frame before it ends.
  // With ov set, the first waiting period carries a stray start bit to provoke an overlap.
  task automatic xfer(input logic [25:0] f, input logic ov, output logic got,
      output logic [17:0] r);
    logic s;
    got = 1'b0;
    r = '0;
    tick(1'b1, s);
    for (int i = 25; i >= 0; i--) tick(f[i], s);
    for (int i = 0; i < 40 && !got; i++)
    begin
      tick(ov && i == 0, s);
      got = s;
    end
    for (int i = 0; i < 18 && got; i++)
    begin
      tick(1'b0, s);
      r = {r[16:0], s};
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module tb_top
  import cir_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_clk, link_cmd, link_ret, sub_req, sub_reset, data_rst, ts_pulse, got;
  logic sub_ack = 1'b0;
  logic ack_err = 1'b0;
  cir_sub_cmd_s sub_cmd, last_cmd;
  logic [17:0] r;
  int err_count = 0, checks_done = 0, cyc = 0, ts_cnt = 0, rst_cnt = 0, sub_cnt = 0, n;
  int ack_dly = 100;
  cir_addr_t bad_a [5] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h1f};
  logic bad_we [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  always #2 clk_i = ~clk_i;
  cir_regs #(.RESET_CYCLES(4), .TIMEOUT_PERIODS(8)) cir_regs_inst (.clk_i(clk_i),
    .rst_i(rst_i), .link_clk_i(link_clk), .link_cmd_i(link_cmd), .link_ret_o(link_ret),
    .sub_req_o(sub_req), .sub_cmd_o(sub_cmd), .sub_ack_i(sub_ack),
    .sub_err_i(sub_ack & ack_err), .sub_rdata_i(sub_ack ? 16'hc3a5 : 16'h3c5a),
    .sub_reset_o(sub_reset), .data_if_reset_o(data_rst), .timestamp_reset_o(ts_pulse));
  cir_host_model cir_host_model_inst (.lclk_o(link_clk), .cmd_o(link_cmd), .ret_i(link_ret));
  // Subsystem stand-in; a delay past the timeout models a dead subsystem.
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    sub_cnt <= sub_req ? sub_cnt + 1 : 0;
    sub_ack <= sub_req && !sub_ack && sub_cnt == ack_dly;
    if (sub_ack) last_cmd <= sub_cmd;
    ts_cnt <= ts_cnt + int'(ts_pulse);
    rst_cnt <= rst_cnt + int'($rose(sub_reset));
    if (cyc == 90000)
    begin
      err_count = err_count + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_rst();
    for (int i = 0; i < 50 && sub_reset !== 1'b0; i++) @(posedge clk_i);
    `CHK(sub_reset, 1'b0)
  endtask
  task automatic acc(input logic we, bc, input cir_addr_t a, input cir_word_t d,
      input logic [1:0] es, input cir_word_t er);
    cir_host_model_inst.xfer({we, bc, a, d}, 1'b0, got, r);
    `CHK(got, !bc)
    if (got) `CHK(r[17:16], es)
    if (got && !we && !es[1]) `CHK(r[15:0], er)
  endtask
  // Status bits 5..4 hold the outcome of the previous access, so only the flags and zero bits are compared.
  task automatic flags(input logic [3:0] e);
    cir_host_model_inst.xfer({2'b00, ADR_STATUS, 16'h0000}, 1'b0, got, r);
    `CHK(r[3:0], e)
    `CHK(r[15:6], 10'h000)
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_rst();
    acc(0, 0, ADR_STATUS, 16'h0000, CIR_RS_OK, 16'h0000);
    acc(0, 0, ADR_CONTROL, 16'h0000, CIR_RS_OK, 16'h0003);
    acc(0, 0, ADR_DELAY, 16'h0000, CIR_RS_OK, 16'h01ff);
    `CHK(data_rst, 1'b0)
    acc(1, 0, ADR_CONTROL, 16'hfffa, CIR_RS_OK, 16'h0000);
    `CHK(data_rst, 1'b1)
    acc(0, 0, ADR_CONTROL, 16'h0000, CIR_RS_OK, 16'h0002);
    acc(1, 0, ADR_CONTROL, 16'hffff, CIR_RS_OK, 16'h0000);
    acc(0, 0, ADR_CONTROL, 16'h0000, CIR_RS_OK, 16'h0007);
    `CHK(data_rst, 1'b0)
    $display("test control done");
    foreach (bad_a[i]) acc(bad_we[i], 0, bad_a[i], 16'h5a5a, CIR_RS_UNKNOWN, 16'h0000);
    $display("test unknown done");
    acc(0, 0, 8'h20, 16'h0000, CIR_RS_OK, 16'hc3a5);
    cir_host_model_inst.xfer({2'b00, ADR_DELAY, 16'h0000}, 1'b0, got, r);
    `CHK(r[15:0] inside {[2:5]}, 1'b1)
    ack_dly = 3;
    acc(1, 0, 8'h7f, 16'h1234, CIR_RS_OK, 16'h0000);
    `CHK(last_cmd, {1'b1, 8'h7f, 16'h1234})
    ack_dly = 1000;
    acc(0, 0, 8'h22, 16'h0000, CIR_RS_TIMEOUT, 16'h0000);
    acc(0, 0, ADR_DELAY, 16'h0000, CIR_RS_OK, 16'h01ff);
    flags(4'h8);
    ack_dly = 3;
    ack_err <= 1'b1;
    acc(0, 0, 8'h23, 16'h0000, CIR_RS_FORBID, 16'h0000);
    ack_err <= 1'b0;
    acc(1, 0, ADR_CONTROL, 16'h0003, CIR_RS_OK, 16'h0000);
    acc(1, 0, ADR_CONTROL, 16'h0007, CIR_RS_OK, 16'h0000);
    flags(4'h0);
    $display("test subsystem done");
    acc(0, 1, ADR_STATUS, 16'h0000, CIR_RS_OK, 16'h0000);
    acc(1, 1, ADR_STATUS, 16'h0000, CIR_RS_OK, 16'h0000);
    acc(1, 1, ADR_TSRST, 16'h0000, CIR_RS_OK, 16'h0000);
    acc(1, 0, ADR_TSRST, 16'h0000, CIR_RS_OK, 16'h0000);
    `CHK(ts_cnt, 2)
    flags(4'h6);
    // A start bit while the answer is still going out must be ignored and flagged.
    cir_host_model_inst.xfer({2'b00, ADR_CONTROL, 16'h0000}, 1'b1, got, r);
    `CHK(got, 1'b1)
    `CHK(r[15:0], 16'h0007)
    flags(4'h7);
    acc(1, 1, ADR_CONTROL, 16'h0003, CIR_RS_OK, 16'h0000);
    flags(4'h0);
    $display("test broadcast done");
    n = rst_cnt;
    acc(1, 1, ADR_CONTROL, 16'h0000, CIR_RS_OK, 16'h0000);
    wait_rst();
    `CHK(rst_cnt, n + 1)
    acc(0, 0, ADR_CONTROL, 16'h0000, CIR_RS_OK, 16'h0003);
    `CHK(data_rst, 1'b0)
    acc(0, 0, ADR_DELAY, 16'h0000, CIR_RS_OK, 16'h01ff);
    $display("test subsystem reset done");
    end_of_test();
  end
endmodule
bind cir_regs cir_regs_checker #(.RESET_CYCLES(RESET_CYCLES),
  .TIMEOUT_PERIODS(TIMEOUT_PERIODS)) cir_regs_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
  .link_clk_i(link_clk_i), .link_ret_o(link_ret_o), .sub_req_o(sub_req_o),
  .sub_cmd_o(sub_cmd_o), .sub_ack_i(sub_ack_i), .sub_reset_o(sub_reset_o),
  .timestamp_reset_o(timestamp_reset_o));
`default_nettype wire
